// ==== cyclic_cmd_pkg.sv ====
// Package with frame layout, command codes, alarm codes and timing counts
package cyclic_cmd_pkg;

    localparam int FRAME_BYTES = 32;
    localparam int FRAME_BITS = FRAME_BYTES * 8;

    // Byte offsets inside the 32-byte frame
    localparam int OFS_CODE = 0;
    localparam int OFS_WDOG = 1;
    localparam int OFS_CMDSTAT = 2;
    localparam int OFS_SERVO = 4;
    localparam int OFS_IO = 8;
    localparam int OFS_SEL_A = 12;
    localparam int OFS_SEL_B = 16;
    localparam int OFS_MON_A = 20;
    localparam int OFS_MON_B = 24;
    localparam int OFS_MON_C = 28;

    // Command codes
    localparam logic [7:0] CODE_NOP = 8'h00;
    localparam logic [7:0] CODE_RELEASE_CONN = 8'h0F;
    localparam logic [7:0] CODE_APPLY_BRAKE = 8'h21;
    localparam logic [7:0] CODE_RELEASE_BRAKE = 8'h22;
    localparam logic [7:0] CODE_SENSOR_ON = 8'h23;
    localparam logic [7:0] CODE_SENSOR_OFF = 8'h24;

    // Command status word (bytes 2-3): alarm code in [3:0], ready in bit 15
    localparam int STAT_ALM_LSB = 0;
    localparam int STAT_READY_BIT = 15;
    localparam logic [3:0] ALM_NONE = 4'h0;
    localparam logic [3:0] ALM_BAD_PARAM = 4'h9;
    localparam logic [3:0] ALM_STATE = 4'hA;

    // Servo status word bits (bytes 4-7)
    localparam int SV_ON_BIT = 0;
    localparam int POS_READY_BIT = 1;
    localparam int BRAKE_BIT = 2;
    localparam int LIMITS_VALID_BIT = 3;

    // Communication phases
    localparam logic [1:0] PHASE_1 = 2'h1;

    // Release must be seen for this many cycles
    localparam int RELEASE_MIN_CYCLES = 2;

    // Sensor power-up time in ns, turned into clock counts at 5 ns period
    localparam int CLK_PERIOD_NS = 5;
    localparam int SENSOR_SETTLE_NS = 1000;
    localparam int SENSOR_SETTLE_CYC = (SENSOR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b11
    } slave_state_e;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_SEND = 2'b01,
        M_WAIT = 2'b11
    } master_state_e;

endpackage : cyclic_cmd_pkg

// ==== cyclic_cmd_if.sv ====
// Interface carrying one 32-byte command and response frame per cycle
`timescale 1ns/1ps
interface cyclic_cmd_if;
    import cyclic_cmd_pkg::*;
    logic cycleStrobe;
    logic [FRAME_BITS-1:0] cmdFrame;
    logic [FRAME_BITS-1:0] rspFrame;

    modport master (output cycleStrobe, output cmdFrame, input rspFrame);
    modport slave (input cycleStrobe, input cmdFrame, output rspFrame);
endinterface : cyclic_cmd_if

// ==== cmd_slave.sv ====
// Slave end: interprets connection release, brake and sensor commands
`timescale 1ns/1ps
module cmd_slave
    import cyclic_cmd_pkg::*;
#(
    parameter int SETTLE_CYC = SENSOR_SETTLE_CYC
)(
    input wire logic mclk,
    input wire logic sys_rst,
    cyclic_cmd_if.slave link,
    input wire logic absEncoder,
    input wire logic [31:0] encoderPosition,
    input wire logic [31:0] originOffset,
    input wire logic servoOnReq,
    input wire logic [31:0] monitorSelA,
    input wire logic [31:0] monitorSelB,
    input wire logic [31:0] monitorA,
    input wire logic [31:0] monitorB,
    input wire logic [31:0] monitorC,
    output logic servoOn,
    output logic brakeOut,
    output logic sensorPower,
    output logic positionReady,
    output logic limitsValid,
    output logic [31:0] currentPosition,
    output logic [1:0] commPhase
);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    function automatic logic [7:0] frameByte(input logic [FRAME_BITS-1:0] f, input int idx);
        frameByte = f[idx*8 +: 8];
    endfunction : frameByte

    slave_state_e state;
    logic [7:0] rxCode;
    logic [7:0] execCode;
    logic [3:0] alarm;
    logic [15:0] settleCnt;
    logic [7:0] masterWdog;
    logic isRelease;
    logic isKnown;

    assign rxCode = frameByte(link.cmdFrame, OFS_CODE);
    assign isRelease = link.cycleStrobe && (rxCode == CODE_RELEASE_CONN);
    assign isKnown = (rxCode == CODE_APPLY_BRAKE) || (rxCode == CODE_RELEASE_BRAKE)
        || (rxCode == CODE_SENSOR_ON) || (rxCode == CODE_SENSOR_OFF);

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
            execCode <= CODE_NOP;
            alarm <= ALM_NONE;
            settleCnt <= 16'h0000;
            masterWdog <= 8'h00;
        end
        else if (isRelease)
        begin
            state <= ST_IDLE;
            execCode <= CODE_RELEASE_CONN;
            alarm <= ALM_NONE;
            settleCnt <= 16'h0000;
            masterWdog <= 8'h00;
        end
        else
        begin
            case (state)
                ST_IDLE, ST_DONE:
                begin
                    if (link.cycleStrobe && rxCode != CODE_NOP && rxCode != execCode)
                    begin
                        execCode <= rxCode;
                        masterWdog <= frameByte(link.cmdFrame, OFS_WDOG);
                        if (!isKnown)
                        begin
                            alarm <= ALM_BAD_PARAM;
                            state <= ST_DONE;
                        end
                        else if (servoOn && (rxCode == CODE_APPLY_BRAKE
                            || rxCode == CODE_RELEASE_BRAKE))
                        begin
                            alarm <= ALM_STATE;
                            state <= ST_DONE;
                        end
                        else if (rxCode == CODE_SENSOR_ON && absEncoder)
                        begin
                            alarm <= ALM_NONE;
                            settleCnt <= 16'(SETTLE_CYC);
                            state <= ST_BUSY;
                        end
                        else
                        begin
                            alarm <= ALM_NONE;
                            state <= ST_DONE;
                        end
                    end
                end
                ST_BUSY:
                begin
                    // New codes other than a release are ignored until the sensor settles
                    if (settleCnt <= 16'h0001)
                    begin
                        settleCnt <= 16'h0000;
                        state <= ST_DONE;
                    end
                    else
                    begin
                        settleCnt <= settleCnt - 16'h0001;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    logic doneEdge;
    // Known command, differing from the last executed code, that completes at once without alarm
    assign doneEdge = !isRelease && state != ST_BUSY && link.cycleStrobe && isKnown
        && rxCode != execCode
        && !(servoOn && (rxCode == CODE_APPLY_BRAKE || rxCode == CODE_RELEASE_BRAKE))
        && !(rxCode == CODE_SENSOR_ON && absEncoder);

    // ------------------------------------------------------------
    // Brake output
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            brakeOut <= 1'b0;
        else if (doneEdge && rxCode == CODE_APPLY_BRAKE)
            brakeOut <= 1'b1;
        else if (doneEdge && rxCode == CODE_RELEASE_BRAKE)
            brakeOut <= 1'b0;
    end

    // ------------------------------------------------------------
    // Servo state and phase
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            servoOn <= 1'b0;
            commPhase <= PHASE_1;
        end
        else if (isRelease)
        begin
            servoOn <= 1'b0;
            commPhase <= PHASE_1;
        end
        else
        begin
            servoOn <= servoOnReq && (!absEncoder || positionReady);
        end
    end

    // ------------------------------------------------------------
    // Sensor and position validity
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sensorPower <= 1'b0;
            positionReady <= 1'b0;
            limitsValid <= 1'b0;
            currentPosition <= 32'h0000_0000;
        end
        else if (isRelease)
        begin
            // Reinitialised slave has no trusted position
            sensorPower <= 1'b0;
            positionReady <= 1'b0;
            limitsValid <= 1'b0;
        end
        else if (state == ST_BUSY && settleCnt <= 16'h0001)
        begin
            currentPosition <= encoderPosition + originOffset;
            positionReady <= 1'b1;
            limitsValid <= 1'b1;
        end
        else if (link.cycleStrobe && state != ST_BUSY && rxCode == CODE_SENSOR_ON
            && absEncoder && rxCode != execCode)
        begin
            sensorPower <= 1'b1;
        end
        else if (doneEdge && rxCode == CODE_SENSOR_OFF && absEncoder)
        begin
            sensorPower <= 1'b0;
            positionReady <= 1'b0;
            limitsValid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Response frame
    // ------------------------------------------------------------
    logic [15:0] cmdStatus;
    logic [31:0] servoStatus;
    always_comb
    begin
        cmdStatus = 16'h0000;
        cmdStatus[STAT_ALM_LSB +: 4] = alarm;
        cmdStatus[STAT_READY_BIT] = (state != ST_BUSY);
        servoStatus = 32'h0000_0000;
        servoStatus[SV_ON_BIT] = servoOn;
        servoStatus[POS_READY_BIT] = positionReady;
        servoStatus[BRAKE_BIT] = brakeOut;
        servoStatus[LIMITS_VALID_BIT] = limitsValid;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            link.rspFrame <= '0;
        else if (execCode == CODE_RELEASE_CONN)
        begin
            link.rspFrame <= '0;
            link.rspFrame[OFS_CODE*8 +: 8] <= CODE_RELEASE_CONN;
        end
        else
        begin
            link.rspFrame <= '0;
            link.rspFrame[OFS_CODE*8 +: 8] <= execCode;
            link.rspFrame[OFS_WDOG*8 +: 8] <= masterWdog;
            link.rspFrame[OFS_CMDSTAT*8 +: 16] <= cmdStatus;
            link.rspFrame[OFS_SERVO*8 +: 32] <= servoStatus;
            link.rspFrame[OFS_IO*8 +: 32] <= {31'h0000_0000, brakeOut};
            link.rspFrame[OFS_SEL_A*8 +: 32] <= monitorSelA;
            link.rspFrame[OFS_SEL_B*8 +: 32] <= monitorSelB;
            link.rspFrame[OFS_MON_A*8 +: 32] <= monitorA;
            link.rspFrame[OFS_MON_B*8 +: 32] <= monitorB;
            link.rspFrame[OFS_MON_C*8 +: 32] <= monitorC;
        end
    end

endmodule : cmd_slave

// ==== cmd_master.sv ====
// Master end: issues one command and waits for its echo and ready, or sends a release twice
`timescale 1ns/1ps
module cmd_master
    import cyclic_cmd_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    cyclic_cmd_if.master link,
    input wire logic issueReq,
    input wire logic [7:0] issueCode,
    output logic issueReady,
    output logic cmdDone,
    output logic [3:0] doneAlarm
);

    master_state_e state;
    logic [7:0] code;
    logic [7:0] wdog;
    logic [1:0] releaseCnt;
    logic [7:0] echoCode;
    logic echoReady;

    assign echoCode = link.rspFrame[OFS_CODE*8 +: 8];
    assign echoReady = link.rspFrame[OFS_CMDSTAT*8 + STAT_READY_BIT];
    assign issueReady = (state == M_IDLE);

    // ------------------------------------------------------------
    // Issue sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= M_IDLE;
            code <= CODE_NOP;
            wdog <= 8'h00;
            releaseCnt <= 2'h0;
            cmdDone <= 1'b0;
            doneAlarm <= ALM_NONE;
            link.cycleStrobe <= 1'b0;
            link.cmdFrame <= '0;
        end
        else
        begin
            cmdDone <= 1'b0;
            link.cycleStrobe <= 1'b0;
            case (state)
                M_IDLE:
                begin
                    if (issueReq)
                    begin
                        code <= issueCode;
                        releaseCnt <= 2'h0;
                        state <= M_SEND;
                    end
                end
                M_SEND:
                begin
                    link.cmdFrame <= '0;
                    link.cmdFrame[OFS_CODE*8 +: 8] <= code;
                    if (code != CODE_RELEASE_CONN)
                        link.cmdFrame[OFS_WDOG*8 +: 8] <= wdog;
                    wdog <= wdog + 8'h01;
                    link.cycleStrobe <= 1'b1;
                    state <= M_WAIT;
                end
                M_WAIT:
                begin
                    if (code == CODE_RELEASE_CONN)
                    begin
                        // Release completes after enough repeated cycles
                        if (releaseCnt == 2'(RELEASE_MIN_CYCLES - 1))
                        begin
                            cmdDone <= 1'b1;
                            state <= M_IDLE;
                        end
                        else
                        begin
                            releaseCnt <= releaseCnt + 2'h1;
                            state <= M_SEND;
                        end
                    end
                    else if (echoCode == code && echoReady)
                    begin
                        cmdDone <= 1'b1;
                        doneAlarm <= link.rspFrame[OFS_CMDSTAT*8 + STAT_ALM_LSB +: 4];
                        state <= M_IDLE;
                    end
                    else
                    begin
                        state <= M_SEND;
                    end
                end
                default:
                begin
                    state <= M_IDLE;
                end
            endcase
        end
    end

endmodule : cmd_master

// ==== cmd_link_monitor.sv ====
// Checker on the command and response frames between master and slave
`timescale 1ns/1ps
module cmd_link_monitor
    import cyclic_cmd_pkg::*;
#(
    parameter int SETTLE_CYC = SENSOR_SETTLE_CYC
)(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cycleStrobe,
    input wire logic [FRAME_BITS-1:0] cmdFrame,
    input wire logic [FRAME_BITS-1:0] rspFrame
);
    localparam int SETTLE_LIM = SETTLE_CYC + 4;
    logic [7:0] code;
    logic [7:0] echo;
    logic [3:0] alarm;
    logic rdy;
    logic svOn;
    logic brake;
    logic newCmd;
    assign code = cmdFrame[7:0];
    assign echo = rspFrame[7:0];
    assign alarm = rspFrame[19:16];
    assign rdy = rspFrame[31];
    assign svOn = rspFrame[32];
    assign brake = rspFrame[34];
    assign newCmd = cycleStrobe && rdy && code != 8'h00 && code != echo;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_rel_frame;
        cycleStrobe && code == CODE_RELEASE_CONN |-> ##2 echo == 8'h0F && rspFrame[255:8] == '0;
    endproperty
    a_rel_frame: assert property (p_rel_frame)
        else $error("release response frame wrong");
    property p_echo;
        newCmd |-> ##2 echo == $past(code, 2);
    endproperty
    a_echo: assert property (p_echo)
        else $error("response code is not the executed one");
    property p_bad_code;
        newCmd && !(code inside {8'h0F, 8'h21, 8'h22, 8'h23, 8'h24}) |-> ##2 alarm == 4'h9;
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("unknown code without alarm 9");
    property p_apply_brake_cmd;
        newCmd && code == 8'h21 && !svOn |-> ##2 brake && alarm == 4'h0;
    endproperty
    a_apply_brake_cmd: assert property (p_apply_brake_cmd)
        else $error("brake not applied");
    property p_release_brake_cmd;
        newCmd && code == 8'h22 && !svOn |-> ##2 !brake && alarm == 4'h0;
    endproperty
    a_release_brake_cmd: assert property (p_release_brake_cmd)
        else $error("brake not released");
    property p_brk_refuse;
        newCmd && code inside {8'h21, 8'h22} && svOn
            |-> ##2 alarm == 4'hA && brake == $past(brake, 2);
    endproperty
    a_brk_refuse: assert property (p_brk_refuse)
        else $error("brake command in servo-on not refused");
    property p_sensor_power_off_cmd;
        newCmd && code == 8'h24 |-> ##[1:SETTLE_LIM] rdy && !rspFrame[33] && !rspFrame[35];
    endproperty
    a_sensor_power_off_cmd: assert property (p_sensor_power_off_cmd)
        else $error("position still valid after sensor off");
    property p_sensor_power_on_cmd;
        newCmd && code == 8'h23 |-> ##[1:SETTLE_LIM] rdy && echo == 8'h23;
    endproperty
    a_sensor_power_on_cmd: assert property (p_sensor_power_on_cmd)
        else $error("sensor on not completed in time");
    property p_busy;
        cycleStrobe && !rdy && code != 8'h0F && echo != 8'h0F |=> echo == $past(echo);
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy command preempted");

    c_release: cover property (cycleStrobe && code == 8'h0F ##2 cycleStrobe && code == 8'h0F);
    c_alarm_state: cover property (rdy && alarm == 4'hA);
    c_settle: cover property (!rdy && echo == 8'h23 ##1 rdy);
endmodule : cmd_link_monitor

// ==== tb_top.sv ====
// Testbench joining master and slave ends with a reference model
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
    import cyclic_cmd_pkg::*;
    logic mclk, sys_rst, absEncoder, servoOnReq, issueReq;
    logic [31:0] encoderPosition, originOffset, monitorSelA, monitorSelB;
    logic [31:0] monitorA, monitorB, monitorC, currentPosition, mCur;
    logic [7:0] issueCode;
    logic servoOn, brakeOut, sensorPower, positionReady, limitsValid, issueReady, cmdDone;
    logic [1:0] commPhase;
    logic [3:0] doneAlarm, alm;
    logic mSv, mBrake, mPwr, mPos, mLim;
    int err_total, samples_checked, relStrobes;

    cyclic_cmd_if link();
    cmd_slave #(.SETTLE_CYC(2)) cmd_slave_inst (.mclk, .sys_rst, .link(link), .absEncoder,
        .encoderPosition, .originOffset, .servoOnReq, .monitorSelA, .monitorSelB,
        .monitorA, .monitorB, .monitorC, .servoOn, .brakeOut, .sensorPower,
        .positionReady, .limitsValid, .currentPosition, .commPhase);
    cmd_master cmd_master_inst (.mclk, .sys_rst, .link(link), .issueReq, .issueCode,
        .issueReady, .cmdDone, .doneAlarm);
    cmd_link_monitor #(.SETTLE_CYC(2)) cmd_link_monitor_inst (.mclk, .sys_rst,
        .cycleStrobe(link.cycleStrobe), .cmdFrame(link.cmdFrame), .rspFrame(link.rspFrame));

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge mclk)
        if (link.cycleStrobe === 1'b1 && link.cmdFrame[7:0] === CODE_RELEASE_CONN)
            relStrobes++;

    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // Bounded wait on a signal at falling edges
    task automatic wait_for(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 300)
        begin
            @(negedge mclk);
            n++;
        end
        if (n >= 300)
        begin
            err_total++;
            tally_and_finish();
        end
    endtask : wait_for

    task automatic issue(input logic [7:0] c);
        @(negedge mclk);
        `CHK(issueReady, 1'b1)
        issueCode = c;
        issueReq = 1'b1;
        @(negedge mclk);
        issueReq = 1'b0;
        wait_for(cmdDone, 1'b1);
    endtask : issue

    task automatic step(input logic [7:0] c);
        alm = ALM_NONE;
        case (c)
            CODE_APPLY_BRAKE, CODE_RELEASE_BRAKE:
                if (mSv) alm = ALM_STATE;
                else mBrake = (c == CODE_APPLY_BRAKE);
            CODE_SENSOR_ON:
                if (absEncoder)
                begin
                    {mPwr, mPos, mLim} = 3'b111;
                    mCur = encoderPosition + originOffset;
                end
            CODE_SENSOR_OFF:
                if (absEncoder) {mPwr, mPos, mLim} = 3'b000;
            default:
                alm = ALM_BAD_PARAM;
        endcase
        issue(c);
        `CHK(doneAlarm, alm)
        `CHK(link.rspFrame[7:0], c)
        `CHK(link.rspFrame[35:32], {mLim, mBrake, mPos, mSv})
        `CHK(link.rspFrame[255:96], {monitorC, monitorB, monitorA, monitorSelB, monitorSelA})
        `CHK({brakeOut, sensorPower, positionReady, limitsValid}, {mBrake, mPwr, mPos, mLim})
        if (mPos)
            `CHK(currentPosition, mCur)
    endtask : step

    task automatic servo(input logic v);
        servoOnReq = v;
        wait_for(servoOn, v);
        mSv = v;
    endtask : servo

    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (6) @(negedge mclk);
        sys_rst = 1'b0;
        {mSv, mBrake, mPwr, mPos, mLim} = 5'b00000;
        `CHK(commPhase, PHASE_1)
    endtask : do_reset

    initial
    begin
        {absEncoder, servoOnReq, issueReq, issueCode} = '0;
        {err_total, samples_checked, relStrobes} = '0;
        sys_rst = 1'b1;
        void'($urandom(40));
        {encoderPosition, originOffset, monitorSelA} = {$urandom, $urandom, $urandom};
        {monitorSelB, monitorA, monitorB, monitorC} = {$urandom, $urandom, $urandom, $urandom};
        do_reset();
        absEncoder = 1'b1;
        step(CODE_APPLY_BRAKE);
        step(CODE_RELEASE_BRAKE);
        step(CODE_SENSOR_ON);
        servo(1'b1);
        step(CODE_APPLY_BRAKE);
        step(CODE_RELEASE_BRAKE);
        step(8'h40 + 8'($urandom_range(0, 63)));
        servo(1'b0);
        step(CODE_SENSOR_OFF);
        absEncoder = 1'b0;
        step(CODE_SENSOR_ON);
        step(CODE_SENSOR_OFF);
        absEncoder = 1'b1;
        step(CODE_SENSOR_ON);
        servo(1'b1);
        issue(CODE_RELEASE_CONN);
        repeat (4) @(negedge mclk);
        `CHK(relStrobes >= 2, 1'b1)
        `CHK(servoOn, 1'b0)
        `CHK(commPhase, PHASE_1)
        `CHK(positionReady, 1'b0)
        servoOnReq = 1'b0;
        do_reset();
        step(CODE_APPLY_BRAKE);
        tally_and_finish();
    end
endmodule : tb_top
